// file: bench/core_pipe_model.sv
`timescale 1ns/10ps
module core_pipe_model (
  input wire logic clk_in,
  input wire logic valid_in,
  input wire logic grant_in,
  input wire logic [2:0] traps_in,
  output logic access_valid_out = 1'b0,
  output logic [1:0] access_kind_out = 2'b11,
  output logic [31:0] access_addr_out = 32'h0,
  output logic special_out = 1'b0,
  output logic paged_out = 1'b0
);
  // one access for one cycle; kind returns to 2'b11, the other released lines show the inverse of the last value
  task automatic issue(input logic [1:0] k, input logic [31:0] a, input logic sp, input logic pg,
                       output logic [4:0] got);
    @(posedge clk_in);
    access_valid_out <= 1'b1;
    access_kind_out <= k;
    access_addr_out <= a;
    special_out <= sp;
    paged_out <= pg;
    @(posedge clk_in);
    access_valid_out <= 1'b0;
    access_kind_out <= 2'b11;
    access_addr_out <= ~a;
    special_out <= ~sp;
    paged_out <= ~pg;
    #1;
    got = {valid_in, grant_in, traps_in};
  endtask
endmodule // core_pipe_model

// file: bench/range_guard_chk.sv
`timescale 1ns/10ps
module range_guard_chk (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic access_valid_in,
  input wire logic [1:0] access_kind_in,
  input wire logic access_special_space_in,
  input wire logic access_paged_in,
  input wire logic verdict_valid_out,
  input wire logic verdict_grant_out,
  input wire logic [1:0] verdict_kind_out,
  input wire logic store_violation_trap_out,
  input wire logic load_violation_trap_out,
  input wire logic fetch_violation_trap_out
);
  logic acc;
  logic [2:0] traps;
  assign acc = access_valid_in && access_kind_in != 2'b11;
  assign traps = {fetch_violation_trap_out, load_violation_trap_out, store_violation_trap_out};
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_answer; acc |=> verdict_valid_out; endproperty
  a_answer: assert property (p_answer) else $error("verdict missing after access");
  property p_quiet; !acc |=> !verdict_valid_out; endproperty
  a_quiet: assert property (p_quiet) else $error("verdict without access");
  property p_kind; acc |=> verdict_kind_out == $past(access_kind_in); endproperty
  a_kind: assert property (p_kind) else $error("verdict kind differs from access kind");
  property p_store;
    store_violation_trap_out |-> verdict_valid_out && !verdict_grant_out && verdict_kind_out == 2'b01;
  endproperty
  a_store: assert property (p_store) else $error("store trap without denied store");
  property p_load;
    load_violation_trap_out |-> verdict_valid_out && !verdict_grant_out && verdict_kind_out == 2'b00;
  endproperty
  a_load: assert property (p_load) else $error("load trap without denied load");
  property p_fetch;
    fetch_violation_trap_out |-> verdict_valid_out && !verdict_grant_out && verdict_kind_out == 2'b10;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch trap without denied fetch");
  property p_traps; $countones(traps) == ((verdict_valid_out && !verdict_grant_out) ? 1 : 0); endproperty
  a_traps: assert property (p_traps) else $error("trap count does not match verdict");
  property p_special; acc && (access_special_space_in || access_paged_in) |=> verdict_grant_out && traps == 3'h0; endproperty
  a_special: assert property (p_special) else $error("unchecked space access denied");
  property p_wait; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_wait_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer longer than one cycle");
endmodule // range_guard_chk
bind range_guard range_guard_chk i_range_guard_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .access_valid_in(access_valid_in),
  .access_kind_in(access_kind_in), .access_special_space_in(access_special_space_in),
  .access_paged_in(access_paged_in), .verdict_valid_out(verdict_valid_out), .verdict_grant_out(verdict_grant_out),
  .verdict_kind_out(verdict_kind_out), .store_violation_trap_out(store_violation_trap_out),
  .load_violation_trap_out(load_violation_trap_out), .fetch_violation_trap_out(fetch_violation_trap_out));

// file: bench/range_guard_tb.sv
`timescale 1ns/10ps
module range_guard_tb;
  import range_guard_pkg::*;
  localparam logic [4:0] GR = 5'h18;
  localparam logic [4:0] DL = 5'h12;
  localparam logic [4:0] DS = 5'h11;
  localparam logic [4:0] DF = 5'h14;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [9:0] bus_addr = 10'h0;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  logic [3:0] bus_be = 4'hF;
  logic [31:0] bus_wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic sel_status = 1'b0;
  logic [1:0] set_num = 2'h0;
  logic valid, special, paged, v_valid, v_grant, irq;
  logic [1:0] kind, v_kind;
  logic [31:0] addr;
  logic [2:0] traps;
  int num_errors = 0;
  int tests_run = 0;
  always #5 mclk_in = ~mclk_in;
  range_guard i_range_guard (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(bus_addr),
    .avs_read_in(bus_rd), .avs_write_in(bus_wr), .avs_byteenable_in(bus_be), .avs_writedata_in(bus_wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .access_valid_in(valid), .access_kind_in(kind),
    .access_addr_in(addr), .access_special_space_in(special), .access_paged_in(paged),
    .set_from_status_in(sel_status), .active_set_number_in(set_num), .verdict_valid_out(v_valid),
    .verdict_grant_out(v_grant), .verdict_kind_out(v_kind), .store_violation_trap_out(traps[0]),
    .load_violation_trap_out(traps[1]), .fetch_violation_trap_out(traps[2]), .irq_out(irq));
  core_pipe_model i_core_pipe_model (.clk_in(mclk_in), .valid_in(v_valid), .grant_in(v_grant), .traps_in(traps),
    .access_valid_out(valid), .access_kind_out(kind), .access_addr_out(addr), .special_out(special),
    .paged_out(paged));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    bus_addr <= a;
    bus_wdata <= d;
    bus_be <= b;
    bus_rd <= !w;
    bus_wr <= w;
    do begin
      @(posedge mclk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      results();
    end
    q = rdata;
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask
  task automatic acc(input logic [1:0] k, input logic [31:0] a, input logic [4:0] e, input logic sp = 1'b0,
                     input logic pg = 1'b0);
    logic [4:0] got;
    i_core_pipe_model.issue(k, a, sp, pg, got);
    chk({27'h0, got}, {27'h0, e});
  endtask
  task automatic results();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    results();
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(OFF_CONTROL, CONTROL_RESET);
    acc(ACC_LOAD, 32'h0, GR);
    wr(10'h100, 32'h1007);
    wr(10'h104, 32'h2005);
    rd(10'h100, 32'h1000);
    rd(10'h104, 32'h2000);
    wr(10'h118, 32'h12345678, 4'h1);
    rd(10'h118, 32'h78);
    wr(10'h200, 32'h3000);
    wr(10'h204, 32'h4000);
    wr(10'h080, 32'h5);
    wr(10'h110, 32'h1000);
    wr(10'h114, 32'h1800);
    wr(10'h088, 32'h2);
    wr(10'h108, 32'h5000);
    wr(10'h10C, 32'h6000);
    wr(10'h084, 32'h3);
    wr(OFF_CONTROL, 32'h1);
    acc(ACC_LOAD, 32'h0FFC, DL);
    acc(ACC_LOAD, 32'h1000, GR);
    acc(ACC_LOAD, 32'h1FFC, GR);
    acc(ACC_LOAD, 32'h2000, DL);
    acc(ACC_STORE, 32'h17FC, GR);
    acc(ACC_STORE, 32'h1800, DS);
    acc(ACC_FETCH, 32'h1000, DF);
    acc(ACC_FETCH, 32'h3000, GR);
    acc(ACC_LOAD, 32'h3000, DL);
    acc(ACC_LOAD, 32'h5000, DL);
    acc(ACC_STORE, 32'h0, GR, 1'b1, 1'b0);
    acc(ACC_FETCH, 32'h0, GR, 1'b0, 1'b1);
    acc(ACC_NONE, 32'h0, 5'h08);
    rd(OFF_FAULT_ADDR, 32'h5000);
    rd(OFF_STATUS, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_CLEAR, 32'h7);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_IRQ_ENABLE, 32'h2);
    acc(ACC_STORE, 32'h1800, DS);
    chk({31'h0, irq}, 32'h0);
    acc(ACC_LOAD, 32'h2000, DL);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_CLEAR, 32'h2);
    rd(OFF_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(OFF_IRQ_CLEAR, 32'h0);
    wr(10'h040, 32'h1);
    acc(ACC_LOAD, 32'h5000, GR);
    acc(ACC_LOAD, 32'h1000, DL);
    wr(10'h040, 32'h0);
    wr(10'h0C0, 32'h2);
    @(posedge mclk_in);
    sel_status <= 1'b1;
    set_num <= 2'h1;
    acc(ACC_STORE, 32'h1000, GR);
    acc(ACC_LOAD, 32'h1000, DL);
    acc(ACC_FETCH, 32'h3000, DF);
    @(posedge mclk_in);
    set_num <= 2'h0;
    acc(ACC_LOAD, 32'h1000, GR);
    @(posedge mclk_in);
    set_num <= 2'h3;
    acc(ACC_LOAD, 32'h1000, DL);
    @(posedge mclk_in);
    sel_status <= 1'b0;
    wr(OFF_CONTROL, 32'h11);
    acc(ACC_LOAD, 32'h1000, DL);
    acc(ACC_STORE, 32'h1000, GR);
    rd(10'h3FC, UNMAPPED_READ);
    wr(OFF_CONTROL, 32'h0);
    acc(ACC_LOAD, 32'h9000, GR);
    results();
  end
endmodule // range_guard_tb

// file: core/pair_select.sv
`timescale 1ns/10ps
module pair_select
  import range_guard_pkg::*;
#(
  parameter int RANGES = 8
) (
  input wire logic [MAX_PAIRS-1:0] choice_in,
  output logic [RANGES-1:0] selected_out
);
  // range 2p is picked by choice 0, range 2p+1 by choice 1
  always_comb begin
    for (int i = 0; i < RANGES; i++) begin
      selected_out[i] = choice_in[i/2] == logic'(i % 2);
    end
  end
endmodule // pair_select

// file: core/range_guard.sv
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - inside means lower <= address < upper
// - data ranges for loads/stores, code for fetches
// - four to sixteen code and data ranges
// - boundaries held at 8-byte resolution
// - low three boundary bits ignore writes, read zero
// - load, store, fetch each have own permit flag
// - each set has per-range permit flags
// - two to four protection sets
// - one set holds code and data permissions
// - check against set chosen by status word field
// - peripheral and emulator space skip checking
// - only direct-translated addresses are checked
// - guard bit low permits everything
// - any containing selected range with its permit flag set grants; none denies
// - three distinct traps for store, load, fetch
// - per-set choice flag picks one range per pair
module range_guard
  import range_guard_pkg::*;
#(
  parameter int CODE_RANGES = CODE_RANGES_DEF,
  parameter int DATA_RANGES = DATA_RANGES_DEF,
  parameter int SETS = SETS_DEF
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [BUS_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  output logic [DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic access_valid_in,
  input wire logic [1:0] access_kind_in,
  input wire logic [ADDR_W-1:0] access_addr_in,
  input wire logic access_special_space_in,
  input wire logic access_paged_in,
  input wire logic set_from_status_in,
  input wire logic [SET_NUM_W-1:0] active_set_number_in,
  output logic verdict_valid_out,
  output logic verdict_grant_out,
  output logic [1:0] verdict_kind_out,
  output logic store_violation_trap_out,
  output logic load_violation_trap_out,
  output logic fetch_violation_trap_out,
  output logic irq_out
);
  localparam int DPAIRS = DATA_RANGES / 2;
  localparam int CPAIRS = CODE_RANGES / 2;

  typedef struct packed {
    bus_state_t bus;
    logic [DATA_W-1:0] rdata;
    logic guard_active_bit;
    logic [SET_NUM_W-1:0] sw_set;
    logic [2:0] status;
    logic [2:0] irq_en;
    logic [ADDR_W-1:0] fault_addr;
    logic [SETS-1:0][MAX_PAIRS-1:0] data_choice;
    logic [SETS-1:0][MAX_PAIRS-1:0] code_choice;
    logic [SETS-1:0][DATA_RANGES-1:0] load_permit_flag;
    logic [SETS-1:0][DATA_RANGES-1:0] store_permit_flag;
    logic [SETS-1:0][CODE_RANGES-1:0] fetch_permit_flag;
    logic [DATA_RANGES-1:0][ADDR_W-1:0] data_lower;
    logic [DATA_RANGES-1:0][ADDR_W-1:0] data_upper;
    logic [CODE_RANGES-1:0][ADDR_W-1:0] code_lower;
    logic [CODE_RANGES-1:0][ADDR_W-1:0] code_upper;
    logic v_valid;
    logic v_grant;
    logic [1:0] v_kind;
    logic trap_store;
    logic trap_load;
    logic trap_fetch;
    logic irq;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [DATA_RANGES-1:0] data_sel;
  logic [CODE_RANGES-1:0] code_sel;
  logic load_ok;
  logic store_ok;
  logic fetch_ok;
  logic [SET_NUM_W-1:0] cur_set;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        old[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = old;
  endfunction

  always_comb begin
    cur_set = set_from_status_in ? active_set_number_in : state_reg.sw_set;
    if (int'(cur_set) >= SETS) begin
      cur_set = '0;
    end
  end

  pair_select #(.RANGES(DATA_RANGES)) u_data_sel (
    .choice_in(state_reg.data_choice[cur_set]),
    .selected_out(data_sel)
  );
  pair_select #(.RANGES(CODE_RANGES)) u_code_sel (
    .choice_in(state_reg.code_choice[cur_set]),
    .selected_out(code_sel)
  );

  range_match #(.RANGES(DATA_RANGES)) u_load (
    .addr_in(access_addr_in),
    .lower_in(state_reg.data_lower),
    .upper_in(state_reg.data_upper),
    .selected_in(data_sel),
    .permit_in(state_reg.load_permit_flag[cur_set]),
    .granted_out(load_ok)
  );
  range_match #(.RANGES(DATA_RANGES)) u_store (
    .addr_in(access_addr_in),
    .lower_in(state_reg.data_lower),
    .upper_in(state_reg.data_upper),
    .selected_in(data_sel),
    .permit_in(state_reg.store_permit_flag[cur_set]),
    .granted_out(store_ok)
  );
  range_match #(.RANGES(CODE_RANGES)) u_fetch (
    .addr_in(access_addr_in),
    .lower_in(state_reg.code_lower),
    .upper_in(state_reg.code_upper),
    .selected_in(code_sel),
    .permit_in(state_reg.fetch_permit_flag[cur_set]),
    .granted_out(fetch_ok)
  );

  always_comb begin
    logic grant;
    logic [2:0] ev;
    logic [9:0] a;
    logic [31:0] rd;
    logic [31:0] wv;
    int idx;
    grant = 1'b1;
    ev = 3'b000;
    a = avs_address_in;
    rd = UNMAPPED_READ;
    wv = 32'h00000000;
    idx = 0;
    state_next = state_reg;

    // verdict, combinational path folded into one registered cycle
    state_next.v_valid = 1'b0;
    state_next.trap_store = 1'b0;
    state_next.trap_load = 1'b0;
    state_next.trap_fetch = 1'b0;
    if (access_valid_in && access_kind_t'(access_kind_in) != ACC_NONE) begin
      if (!state_reg.guard_active_bit || access_special_space_in || access_paged_in) begin
        grant = 1'b1;
      end else begin
        unique case (access_kind_t'(access_kind_in))
          ACC_LOAD: grant = load_ok;
          ACC_STORE: grant = store_ok;
          ACC_FETCH: grant = fetch_ok;
          ACC_NONE: grant = 1'b1;
        endcase
      end
      state_next.v_valid = 1'b1;
      state_next.v_grant = grant;
      state_next.v_kind = access_kind_in;
      if (!grant) begin
        ev[ST_STORE] = access_kind_t'(access_kind_in) == ACC_STORE;
        ev[ST_LOAD] = access_kind_t'(access_kind_in) == ACC_LOAD;
        ev[ST_FETCH] = access_kind_t'(access_kind_in) == ACC_FETCH;
        state_next.fault_addr = access_addr_in;
      end
      state_next.trap_store = ev[ST_STORE];
      state_next.trap_load = ev[ST_LOAD];
      state_next.trap_fetch = ev[ST_FETCH];
    end

    // register bus: one wait cycle, answer on the second
    state_next.bus = BUS_IDLE;
    if (state_reg.bus == BUS_IDLE && (avs_read_in || avs_write_in)) begin
      state_next.bus = BUS_ACK;
      if (a == OFF_CONTROL) begin
        rd[CTRL_GUARD_BIT] = state_reg.guard_active_bit;
        rd[CTRL_SET_LSB +: SET_NUM_W] = state_reg.sw_set;
      end else if (a == OFF_STATUS) begin
        rd[2:0] = state_reg.status;
      end else if (a == OFF_IRQ_ENABLE) begin
        rd[2:0] = state_reg.irq_en;
      end else if (a == OFF_FAULT_ADDR) begin
        rd = state_reg.fault_addr;
      end
      for (int s = 0; s < SETS; s++) begin
        if (a == OFF_DATA_SEL_BASE + 10'(s*4)) begin
          rd[MAX_PAIRS-1:0] = state_reg.data_choice[s];
        end
        if (a == OFF_CODE_SEL_BASE + 10'(s*4)) begin
          rd[MAX_PAIRS-1:0] = state_reg.code_choice[s];
        end
        for (int r = 0; r < DATA_RANGES; r++) begin
          if (a == OFF_PERM_BASE + 10'((s*16 + r)*4)) begin
            rd[PERM_LOAD_BIT] = state_reg.load_permit_flag[s][r];
            rd[PERM_STORE_BIT] = state_reg.store_permit_flag[s][r];
            if (r < CODE_RANGES) begin
              rd[PERM_FETCH_BIT] = state_reg.fetch_permit_flag[s][r % CODE_RANGES];
            end
          end
        end
      end
      for (int r = 0; r < DATA_RANGES; r++) begin
        if (a == OFF_DATA_BOUND_BASE + 10'(r*8)) begin
          rd = state_reg.data_lower[r];
        end
        if (a == OFF_DATA_BOUND_BASE + 10'(r*8 + 4)) begin
          rd = state_reg.data_upper[r];
        end
      end
      for (int r = 0; r < CODE_RANGES; r++) begin
        if (a == OFF_CODE_BOUND_BASE + 10'(r*8)) begin
          rd = state_reg.code_lower[r];
        end
        if (a == OFF_CODE_BOUND_BASE + 10'(r*8 + 4)) begin
          rd = state_reg.code_upper[r];
        end
      end
      state_next.rdata = avs_read_in ? rd : state_reg.rdata;
    end

    // writes take effect on the acknowledging edge
    if (state_reg.bus == BUS_ACK && avs_write_in) begin
      wv = merge(32'h00000000, avs_writedata_in, avs_byteenable_in);
      if (a == OFF_CONTROL) begin
        if (avs_byteenable_in[0]) begin
          state_next.guard_active_bit = wv[CTRL_GUARD_BIT];
          state_next.sw_set = wv[CTRL_SET_LSB +: SET_NUM_W];
        end
      end else if (a == OFF_IRQ_ENABLE) begin
        if (avs_byteenable_in[0]) begin
          state_next.irq_en = wv[2:0];
        end
      end else if (a == OFF_IRQ_CLEAR) begin
        state_next.status = state_reg.status & ~wv[2:0];
      end
      for (int s = 0; s < SETS; s++) begin
        if (a == OFF_DATA_SEL_BASE + 10'(s*4) && avs_byteenable_in[0]) begin
          state_next.data_choice[s] = wv[MAX_PAIRS-1:0] & MAX_PAIRS'((1 << DPAIRS) - 1);
        end
        if (a == OFF_CODE_SEL_BASE + 10'(s*4) && avs_byteenable_in[0]) begin
          state_next.code_choice[s] = wv[MAX_PAIRS-1:0] & MAX_PAIRS'((1 << CPAIRS) - 1);
        end
        for (int r = 0; r < DATA_RANGES; r++) begin
          if (a == OFF_PERM_BASE + 10'((s*16 + r)*4) && avs_byteenable_in[0]) begin
            state_next.load_permit_flag[s][r] = wv[PERM_LOAD_BIT];
            state_next.store_permit_flag[s][r] = wv[PERM_STORE_BIT];
            if (r < CODE_RANGES) begin
              state_next.fetch_permit_flag[s][r % CODE_RANGES] = wv[PERM_FETCH_BIT];
            end
          end
        end
      end
      for (int r = 0; r < DATA_RANGES; r++) begin
        if (a == OFF_DATA_BOUND_BASE + 10'(r*8)) begin
          state_next.data_lower[r] = merge(state_reg.data_lower[r], avs_writedata_in, avs_byteenable_in)
                                     & BOUND_MASK;
        end
        if (a == OFF_DATA_BOUND_BASE + 10'(r*8 + 4)) begin
          state_next.data_upper[r] = merge(state_reg.data_upper[r], avs_writedata_in, avs_byteenable_in)
                                     & BOUND_MASK;
        end
      end
      for (int r = 0; r < CODE_RANGES; r++) begin
        if (a == OFF_CODE_BOUND_BASE + 10'(r*8)) begin
          state_next.code_lower[r] = merge(state_reg.code_lower[r], avs_writedata_in, avs_byteenable_in)
                                     & BOUND_MASK;
        end
        if (a == OFF_CODE_BOUND_BASE + 10'(r*8 + 4)) begin
          state_next.code_upper[r] = merge(state_reg.code_upper[r], avs_writedata_in, avs_byteenable_in)
                                     & BOUND_MASK;
        end
      end
    end

    // new events win over a clear in the same cycle
    state_next.status = state_next.status | ev;
    state_next.irq = |(state_next.status & state_next.irq_en);
    idx = idx;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.guard_active_bit <= CONTROL_RESET[CTRL_GUARD_BIT];
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata_out = state_reg.rdata;
  assign avs_waitrequest_out = !(state_reg.bus == BUS_ACK);
  assign verdict_valid_out = state_reg.v_valid;
  assign verdict_grant_out = state_reg.v_grant;
  assign verdict_kind_out = state_reg.v_kind;
  assign store_violation_trap_out = state_reg.trap_store;
  assign load_violation_trap_out = state_reg.trap_load;
  assign fetch_violation_trap_out = state_reg.trap_fetch;
  assign irq_out = state_reg.irq;
endmodule // range_guard

// file: core/range_guard_pkg.sv
package range_guard_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BUS_AW = 10;
  localparam int GRAN_BITS = 3;
  localparam int CODE_RANGES_DEF = 8;
  localparam int DATA_RANGES_DEF = 16;
  localparam int SETS_DEF = 4;
  localparam int SET_NUM_W = 2;
  localparam int MAX_PAIRS = 8;
  localparam logic [31:0] BOUND_MASK = 32'hFFFFFFF8;
  // register map, byte addresses on a 32-bit word grid
  localparam logic [9:0] OFF_CONTROL = 10'h000;
  localparam logic [9:0] OFF_STATUS = 10'h004;
  localparam logic [9:0] OFF_IRQ_ENABLE = 10'h008;
  localparam logic [9:0] OFF_IRQ_CLEAR = 10'h00C;
  localparam logic [9:0] OFF_FAULT_ADDR = 10'h010;
  localparam logic [9:0] OFF_DATA_SEL_BASE = 10'h040;
  localparam logic [9:0] OFF_CODE_SEL_BASE = 10'h060;
  localparam logic [9:0] OFF_PERM_BASE = 10'h080;
  localparam logic [9:0] OFF_DATA_BOUND_BASE = 10'h100;
  localparam logic [9:0] OFF_CODE_BOUND_BASE = 10'h200;
  localparam int CTRL_GUARD_BIT = 0;
  localparam int CTRL_SET_LSB = 4;
  localparam logic [31:0] CONTROL_RESET = 32'h00000000;
  localparam int ST_STORE = 0;
  localparam int ST_LOAD = 1;
  localparam int ST_FETCH = 2;
  localparam int PERM_LOAD_BIT = 0;
  localparam int PERM_STORE_BIT = 1;
  localparam int PERM_FETCH_BIT = 2;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  typedef enum logic [1:0] {
    ACC_LOAD = 2'b00,
    ACC_STORE = 2'b01,
    ACC_FETCH = 2'b10,
    ACC_NONE = 2'b11
  } access_kind_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;
endpackage

// file: core/range_match.sv
`timescale 1ns/10ps
module range_match
  import range_guard_pkg::*;
#(
  parameter int RANGES = 8
) (
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [RANGES*ADDR_W-1:0] lower_in,
  input wire logic [RANGES*ADDR_W-1:0] upper_in,
  input wire logic [RANGES-1:0] selected_in,
  input wire logic [RANGES-1:0] permit_in,
  output logic granted_out
);
  function automatic logic inside_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                        input logic [ADDR_W-1:0] hi);
    inside_range = (a >= lo) && (a < hi);
  endfunction
  always_comb begin
    granted_out = 1'b0;
    for (int i = 0; i < RANGES; i++) begin
      if (selected_in[i] && permit_in[i] &&
          inside_range(addr_in, lower_in[i*ADDR_W +: ADDR_W], upper_in[i*ADDR_W +: ADDR_W])) begin
        granted_out = 1'b1;
      end
    end
  end
endmodule // range_match
